// File: design/slb_serial_link_at_speed_self_test.sv
// Purpose: serializer-side at-speed self test and pattern source
// Assumes: back-channel frame fields arrive on mclk from the link core
// Notes:   payload goes on to scrambler/dc balance, which stays enabled
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module slb_serial_link_at_speed_self_test (
    input  wire logic        mclk,          // 125 MHz clock
    input  wire logic        rst_b,         // async reset, active low
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output var  logic [31:0] prdata,        // apb read data
    output var  logic        pready,        // apb ready
    output var  logic        pslverr,       // apb error, unmapped
    input  wire logic        bc_frame_vld,  // back-channel frame strobe
    input  wire logic        bc_st_enable,  // frame's self-test enable
    input  wire logic        bc_crc_err,    // frame failed crc
    input  wire logic        bc_lock,       // back-channel lock
    input  wire logic        vid_clk_pres,  // pin: input clock seen
    input  wire logic [23:0] vid_data,      // parallel pixel input
    input  wire logic        vid_de,        // pixel data enable
    output var  logic [23:0] ser_data,      // payload to scrambler
    output var  logic        ser_de,        // payload data enable
    output var  logic        st_active,     // self test running
    output var  logic        ring_clk_sel,  // use internal ring clock
    output var  logic        irq            // level interrupt
);
    // =====================================================
    // input synchroniser for the clock-present pin
    logic clk_pres_s1_r;
    logic clk_pres_s2_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clk_pres_s1_r <= 1'b0;
            clk_pres_s2_r <= 1'b0;
        end else begin
            clk_pres_s1_r <= vid_clk_pres;
            clk_pres_s2_r <= clk_pres_s1_r;
        end
    end

    // =====================================================
    // apb decode
    logic        acc;
    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    assign acc   = psel & penable;
    // ready comes one cycle into the access phase, so data is a flop
    assign wr_en = acc & pwrite & pready;
    assign rd_en = acc & ~pwrite & ~pready;
    always_comb begin
        unique case (paddr)
            slb_pkg::PG_CTRL_OFS, slb_pkg::GEN_CFG_OFS,
            slb_pkg::LINK_STS_OFS, slb_pkg::FN_CRC_OFS,
            slb_pkg::ST_CRC_OFS, slb_pkg::INT_STS_OFS,
            slb_pkg::INT_MSK_OFS, slb_pkg::PG_COLOR_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // =====================================================
    // mode and start sequence state
    slb_pkg::slb_mode_t mode_r;
    slb_pkg::slb_mode_t mode_nxt;
    slb_pkg::slb_seq_t  seq_r;
    slb_pkg::slb_seq_t  seq_nxt;
    logic               req_r;
    logic               req_nxt;
    logic               seq_bit_r;
    logic               seq_bit_nxt;
    logic               enter;
    logic               leave;

    always_comb begin
        req_nxt = req_r;
        // enable is sampled only from frames the link is locked to
        if (bc_frame_vld && bc_lock) begin
            req_nxt = bc_st_enable;
        end
        mode_nxt = mode_r;
        unique case (mode_r)
            slb_pkg::MODE_NORMAL:    if (req_r) begin
                mode_nxt = slb_pkg::MODE_SELF_TEST;
            end
            slb_pkg::MODE_SELF_TEST: if (!req_r) begin
                mode_nxt = slb_pkg::MODE_NORMAL;
            end
        endcase
    end
    assign enter = (mode_r == slb_pkg::MODE_NORMAL) && req_r;
    assign leave = (mode_r == slb_pkg::MODE_SELF_TEST) && !req_r;

    // tracks the host's one-then-zero write to the start bit
    always_comb begin
        seq_bit_nxt = seq_bit_r;
        if (wr_en && paddr == slb_pkg::GEN_CFG_OFS) begin
            seq_bit_nxt = pwdata[slb_pkg::SEQ_BIT];
        end
        seq_nxt = seq_r;
        if (enter) begin
            seq_nxt = slb_pkg::SEQ_WAIT_SET;
        end else if (mode_r == slb_pkg::MODE_SELF_TEST) begin
            unique case (seq_r)
                slb_pkg::SEQ_WAIT_SET: if (seq_bit_nxt) begin
                    seq_nxt = slb_pkg::SEQ_WAIT_CLR;
                end
                slb_pkg::SEQ_WAIT_CLR: if (!seq_bit_nxt) begin
                    seq_nxt = slb_pkg::SEQ_DONE;
                end
                slb_pkg::SEQ_DONE: seq_nxt = slb_pkg::SEQ_DONE;
                default: seq_nxt = slb_pkg::SEQ_WAIT_SET;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r    <= slb_pkg::MODE_NORMAL;
            seq_r     <= slb_pkg::SEQ_WAIT_SET;
            req_r     <= 1'b0;
            seq_bit_r <= 1'b0;
        end else begin
            mode_r    <= mode_nxt;
            seq_r     <= seq_nxt;
            req_r     <= req_nxt;
            seq_bit_r <= seq_bit_nxt;
        end
    end

    // =====================================================
    // back-channel crc error counters
    logic [7:0] fn_crc_r;
    logic [7:0] fn_crc_nxt;
    logic [7:0] st_crc_r;
    logic [7:0] st_crc_nxt;
    logic       crc_hit;
    logic       in_test;
    assign in_test = (mode_r == slb_pkg::MODE_SELF_TEST);
    // before lock the frame boundaries are unknown, so crc is noise
    assign crc_hit = bc_frame_vld & bc_lock & bc_crc_err;

    always_comb begin
        fn_crc_nxt = fn_crc_r;
        st_crc_nxt = st_crc_r;
        if (enter) begin
            fn_crc_nxt = '0;
            st_crc_nxt = '0;
        end else begin
            if (wr_en && paddr == slb_pkg::FN_CRC_OFS) begin
                fn_crc_nxt = '0;
            end
            if (wr_en && paddr == slb_pkg::ST_CRC_OFS) begin
                st_crc_nxt = '0;
            end
            // counts saturate; a hit in the clear cycle still counts unless the count was at CNT_MAX
            if (crc_hit && fn_crc_r != slb_pkg::CNT_MAX) begin
                fn_crc_nxt = fn_crc_nxt + 8'h01;
            end
            if (crc_hit && in_test
                && st_crc_r != slb_pkg::CNT_MAX) begin
                st_crc_nxt = st_crc_nxt + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fn_crc_r <= '0;
            st_crc_r <= '0;
        end else begin
            fn_crc_r <= fn_crc_nxt;
            st_crc_r <= st_crc_nxt;
        end
    end

    // =====================================================
    // configuration, interrupt status and mask
    logic [3:0]  pg_ctrl_r;
    logic [3:0]  pg_ctrl_nxt;
    logic [23:0] pg_color_r;
    logic [23:0] pg_color_nxt;
    logic [2:0]  int_sts_r;
    logic [2:0]  int_sts_nxt;
    logic [2:0]  int_msk_r;
    logic [2:0]  int_msk_nxt;
    logic [2:0]  events;
    assign events = {crc_hit, leave, enter};

    always_comb begin
        pg_ctrl_nxt  = pg_ctrl_r;
        pg_color_nxt = pg_color_r;
        int_msk_nxt  = int_msk_r;
        int_sts_nxt  = int_sts_r;
        if (wr_en && paddr == slb_pkg::PG_CTRL_OFS) begin
            pg_ctrl_nxt = pwdata[3:0];
        end
        if (wr_en && paddr == slb_pkg::PG_COLOR_OFS) begin
            pg_color_nxt = pwdata[23:0];
        end
        if (wr_en && paddr == slb_pkg::INT_MSK_OFS) begin
            int_msk_nxt = pwdata[2:0];
        end
        if (wr_en && paddr == slb_pkg::INT_STS_OFS) begin
            int_sts_nxt = int_sts_r & ~pwdata[2:0];
        end
        // set wins over a simultaneous write-one clear
        int_sts_nxt = int_sts_nxt | events;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pg_ctrl_r  <= slb_pkg::PG_CTRL_RST;
            pg_color_r <= slb_pkg::PG_COLOR_RST;
            int_sts_r  <= '0;
            int_msk_r  <= '0;
        end else begin
            pg_ctrl_r  <= pg_ctrl_nxt;
            pg_color_r <= pg_color_nxt;
            int_sts_r  <= int_sts_nxt;
            int_msk_r  <= int_msk_nxt;
        end
    end

    // =====================================================
    // payload select: zeros, pattern or video
    logic [23:0] pat;
    logic [3:0]  chk_r;
    logic [3:0]  chk_nxt;
    logic [23:0] data_nxt;
    logic        de_nxt;
    logic        ring_nxt;
    logic        pg_on;
    assign pg_on = pg_ctrl_r[slb_pkg::PG_EN_BIT];

    always_comb begin
        chk_nxt = chk_r + 4'h1;
        pat     = pg_color_r;
        if (pg_ctrl_r[slb_pkg::PG_CHK_BIT] && chk_r[3]) begin
            pat = ~pg_color_r;
        end
        if (pg_ctrl_r[slb_pkg::PG_INV_BIT]) begin
            pat = ~pat;
        end
        // with the pattern generator on: ring clock when asked, or when no input clock is seen
        ring_nxt = pg_on && (pg_ctrl_r[slb_pkg::PG_RING_BIT]
                   || !clk_pres_s2_r);
        if (in_test) begin
            // video pins are not looked at; zeros still get scrambled
            data_nxt = '0;
            de_nxt   = 1'b1;
        end else if (pg_on) begin
            // runs every cycle, independent of any video activity
            data_nxt = pat;
            de_nxt   = 1'b1;
        end else begin
            data_nxt = vid_data;
            de_nxt   = vid_de;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            chk_r        <= '0;
            ser_data     <= '0;
            ser_de       <= 1'b0;
            ring_clk_sel <= 1'b0;
            st_active    <= 1'b0;
            irq          <= 1'b0;
        end else begin
            chk_r        <= chk_nxt;
            ser_data     <= data_nxt;
            ser_de       <= de_nxt;
            ring_clk_sel <= ring_nxt;
            // follows the payload mux, so status and zeros change together
            st_active    <= in_test;
            irq          <= |(int_sts_nxt & int_msk_nxt);
        end
    end

    // =====================================================
    // apb read data and answer
    logic [31:0] rd_val;
    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;

    always_comb begin
        rd_val = '0;
        unique case (paddr)
            slb_pkg::PG_CTRL_OFS:  rd_val[3:0]  = pg_ctrl_r;
            slb_pkg::GEN_CFG_OFS:  rd_val[slb_pkg::SEQ_BIT] = seq_bit_r;
            slb_pkg::LINK_STS_OFS: begin
                rd_val[slb_pkg::LINK_DET_BIT]  = bc_lock;
                rd_val[slb_pkg::ST_ACTIVE_BIT] = in_test;
                rd_val[slb_pkg::SEQ_DONE_BIT]  =
                    (seq_r == slb_pkg::SEQ_DONE);
                rd_val[slb_pkg::CLK_PRES_BIT]  = clk_pres_s2_r;
            end
            slb_pkg::FN_CRC_OFS:   rd_val[7:0]  = fn_crc_r;
            slb_pkg::ST_CRC_OFS:   rd_val[7:0]  = st_crc_r;
            slb_pkg::INT_STS_OFS:  rd_val[2:0]  = int_sts_r;
            slb_pkg::INT_MSK_OFS:  rd_val[2:0]  = int_msk_r;
            slb_pkg::PG_COLOR_OFS: rd_val[23:0] = pg_color_r;
            default:               rd_val       = '0;
        endcase
        pready_nxt  = acc & ~pready;
        pslverr_nxt = acc & ~pready & ~mapped;
        prdata_nxt  = prdata;
        if (rd_en) begin
            prdata_nxt = rd_val;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end
endmodule : slb_serial_link_at_speed_self_test
`default_nettype wire

// File: design/slb_pkg.sv
// Purpose: shared constants for the serial link self-test block
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   offsets 0x04 and 0x0C hold the documented control/status bits
package slb_pkg;
    // =====================================================
    // register offsets
    localparam logic [7:0] PG_CTRL_OFS  = 8'h00;
    localparam logic [7:0] GEN_CFG_OFS  = 8'h04;
    localparam logic [7:0] LINK_STS_OFS = 8'h0C;
    localparam logic [7:0] FN_CRC_OFS   = 8'h10;
    localparam logic [7:0] ST_CRC_OFS   = 8'h14;
    localparam logic [7:0] INT_STS_OFS  = 8'h18;
    localparam logic [7:0] INT_MSK_OFS  = 8'h1C;
    localparam logic [7:0] PG_COLOR_OFS = 8'h20;
    // =====================================================
    // field positions
    localparam int PG_EN_BIT     = 0;
    localparam int PG_RING_BIT   = 1;
    localparam int PG_INV_BIT    = 2;
    localparam int PG_CHK_BIT    = 3;
    localparam int SEQ_BIT       = 5;
    localparam int LINK_DET_BIT  = 0;
    localparam int ST_ACTIVE_BIT = 1;
    localparam int SEQ_DONE_BIT  = 2;
    localparam int CLK_PRES_BIT  = 3;
    localparam int EV_ENTER_BIT  = 0;
    localparam int EV_EXIT_BIT   = 1;
    localparam int EV_CRC_BIT    = 2;
    // =====================================================
    // widths and reset values
    localparam int          PIX_W     = 24;
    localparam int          CNT_W     = 8;
    localparam int          EV_W      = 3;
    localparam int          CHK_W     = 4;
    localparam logic [7:0]  CNT_MAX   = 8'hFF;
    localparam logic [3:0]  PG_CTRL_RST  = 4'h1;
    localparam logic [23:0] PG_COLOR_RST = 24'hFFFFFF;
    // =====================================================
    // types
    typedef enum logic {
        MODE_NORMAL,
        MODE_SELF_TEST
    } slb_mode_t;
    typedef enum logic [1:0] {
        SEQ_WAIT_SET,
        SEQ_WAIT_CLR,
        SEQ_DONE
    } slb_seq_t;
endpackage : slb_pkg

// File: bench/slb_bc_model.sv
// Purpose: far-end deserializer model: back-channel frames, payload check
// Assumes: one frame every four mclk cycles
// Notes:   unqualified fields show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module slb_bc_model (
    input  wire logic        mclk,         // chosen test clock
    input  wire logic        rst_b,        // reset, active low
    input  wire logic [23:0] ser_data,     // forward payload
    input  wire logic        ser_de,       // forward payload enable
    input  wire logic        st_active,    // far end in self test
    output var  logic        bc_frame_vld, // frame strobe
    output var  logic        bc_st_enable, // self-test enable field
    output var  logic        bc_crc_err,   // crc error field
    output var  logic        bc_lock       // lock level
);
    logic       st_on   = 1'b0;
    logic       lock_on = 1'b0;
    int         bad_n   = 0;
    logic [1:0] ph;
    logic       pass_r;     // result pin level
    logic       run_r;      // checked in the last cycle
    int         err_frames; // low pulses shown on the result pin
    logic       checking;
    assign checking = st_on & bc_lock & st_active;
    // =====================================================
    // frame generator
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {ph, bc_frame_vld, bc_st_enable, bc_crc_err, bc_lock} <= '0;
        end else begin
            ph      <= ph + 2'h1;
            bc_lock <= lock_on;
            if (ph == 2'h3) begin
                bc_frame_vld <= 1'b1;
                bc_st_enable <= st_on;
                bc_crc_err   <= (bad_n > 0);
                if (bad_n > 0) bad_n <= bad_n - 1;
            end else begin
                bc_frame_vld <= 1'b0;
                bc_st_enable <= ~bc_st_enable;
                bc_crc_err   <= ~bc_crc_err;
            end
        end
    end
    // =====================================================
    // result pin: a one-cycle low stands in for the half-period pulse
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pass_r     <= 1'b0;
            run_r      <= 1'b0;
            err_frames <= 0;
        end else begin
            run_r <= checking;
            if (checking && !run_r) begin
                pass_r     <= 1'b1;
                err_frames <= 0;
            end else if (checking) begin
                pass_r <= (ser_de === 1'b1 && ser_data === 24'h000000);
                if (ser_de !== 1'b1 || ser_data !== 24'h000000) begin
                    err_frames <= err_frames + 1;
                end
            end else if (run_r) begin
                pass_r <= (err_frames == 0);
            end
        end
    end
endmodule : slb_bc_model
`default_nettype wire

// File: bench/slb_chk_sva.sv
// Purpose: port checker for the serial link self-test block
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ns
`default_nettype none
module slb_chk (
    input wire logic        mclk,         // clock
    input wire logic        rst_b,        // reset
    input wire logic        psel,         // apb select
    input wire logic        penable,      // apb access
    input wire logic        pready,       // apb ready
    input wire logic        pslverr,      // apb error
    input wire logic        bc_frame_vld, // frame strobe
    input wire logic        bc_st_enable, // enable field
    input wire logic        bc_lock,      // lock
    input wire logic [23:0] ser_data,     // payload
    input wire logic        ser_de,       // payload enable
    input wire logic        st_active,    // in self test
    input wire logic        ring_clk_sel  // ring clock used
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // =====================================================
    // assertions
    st_entry_a: assert property (
        bc_frame_vld && bc_lock && bc_st_enable |-> ##3 st_active)
        else $error("self test not entered");
    st_exit_a: assert property (
        bc_frame_vld && bc_lock && !bc_st_enable |-> ##3 !st_active)
        else $error("self test not left");
    zero_payload_a: assert property (
        st_active |-> ser_data == 24'h000000 && ser_de)
        else $error("payload not zero in test");
    no_lock_a: assert property (
        !bc_lock [*3] |-> $stable(st_active))
        else $error("frame taken without lock");
    ring_sel_a: assert property (
        ring_clk_sel |-> ser_de)
        else $error("ring clock without pattern");
    apb_wait_a: assert property (
        psel && $rose(penable) |-> !pready ##1 pready)
        else $error("wrong wait states");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : slb_chk
bind slb_serial_link_at_speed_self_test slb_chk u_chk (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .bc_frame_vld(bc_frame_vld),
    .bc_st_enable(bc_st_enable), .bc_lock(bc_lock),
    .ser_data(ser_data), .ser_de(ser_de), .st_active(st_active),
    .ring_clk_sel(ring_clk_sel));
`default_nettype wire

// File: bench/tb.sv
// Purpose: self-checking bench for the serial link self-test block
// Assumes: apb answers with one wait state
// Notes:   addresses from package constants except the unmapped 0x08; most expectations are literal values
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, rerr, bc_frame_vld, bc_st_enable, bc_crc_err, bc_lock;
    logic vid_clk_pres = 1'b0, vid_de = 1'b0, ser_de, st_active, ring_clk_sel, irq;
    logic [23:0] vid_data = '0, ser_data, pv;
    int fail_count = 0, checks_done = 0;
    initial forever #4 mclk = ~mclk;
    slb_bc_model u_bc (.mclk(mclk), .rst_b(rst_b), .ser_data(ser_data), .ser_de(ser_de),
        .st_active(st_active), .bc_frame_vld(bc_frame_vld),
        .bc_st_enable(bc_st_enable), .bc_crc_err(bc_crc_err), .bc_lock(bc_lock));
    slb_serial_link_at_speed_self_test i_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bc_frame_vld(bc_frame_vld), .bc_st_enable(bc_st_enable),
        .bc_crc_err(bc_crc_err), .bc_lock(bc_lock), .vid_clk_pres(vid_clk_pres),
        .vid_data(vid_data), .vid_de(vid_de), .ser_data(ser_data), .ser_de(ser_de),
        .st_active(st_active), .ring_clk_sel(ring_clk_sel), .irq(irq));
    // =====================================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // request stands until pready is seen high at a rising edge
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) chk("pready", 32'h0, 32'h1);
        rd   = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, '0);
        chk(nm, rd, e);
    endtask : rchk
    task automatic wait_st(input logic lvl);
        int n;
        for (n = 0; n < 40 && st_active !== lvl; n++) @(posedge mclk);
        chk("st_active", st_active, lvl);
    endtask : wait_st
    task automatic frames(input int bad);
        u_bc.bad_n <= bad;
        repeat (4 * bad + 12) @(posedge mclk);
    endtask : frames
    task automatic summarize();
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    initial begin
        #200000;
        fail_count++;
        summarize();
    end
    // =====================================================
    // tests
    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (5) @(posedge mclk);
        chk("ring", ring_clk_sel, 1);
        chk("pattern", {ser_de, ser_data}, {1'b1, slb_pkg::PG_COLOR_RST});
        vid_clk_pres <= 1'b1;
        rchk("pg_ctrl", slb_pkg::PG_CTRL_OFS, 32'h1);
        rchk("pg_color", slb_pkg::PG_COLOR_OFS, 32'hFFFFFF);
        rchk("int_msk", slb_pkg::INT_MSK_OFS, 32'h0);
        chk("ring", ring_clk_sel, 0);
        xfer(1'b1, slb_pkg::PG_CTRL_OFS, 32'h3);
        repeat (2) @(posedge mclk);
        chk("ring", ring_clk_sel, 1);
        xfer(1'b1, slb_pkg::PG_COLOR_OFS, 32'h123456);
        xfer(1'b1, slb_pkg::PG_CTRL_OFS, 32'h5);
        repeat (2) @(posedge mclk);
        chk("inverted", ser_data, 32'hEDCBA9);
        chk("ring", ring_clk_sel, 0);
        xfer(1'b1, slb_pkg::PG_CTRL_OFS, 32'h9);
        repeat (2) @(posedge mclk);
        pv = ser_data;
        repeat (8) @(posedge mclk);
        chk("checker", pv ^ ser_data, 32'hFFFFFF);
        xfer(1'b1, slb_pkg::PG_CTRL_OFS, 32'h0);
        xfer(1'b0, 8'h08, '0);
        chk("unmapped_err", rerr, 1);
        chk("unmapped", rd, 0);
        vid_data <= 24'hA5C3E1;
        vid_de   <= 1'b1;
        u_bc.st_on <= 1'b1;
        frames(2);
        chk("st_unlocked", st_active, 0);
        rchk("fn_crc", slb_pkg::FN_CRC_OFS, 32'h0);
        u_bc.st_on   <= 1'b0;
        u_bc.lock_on <= 1'b1;
        frames(3);
        rchk("fn_crc", slb_pkg::FN_CRC_OFS, 32'h3);
        xfer(1'b1, slb_pkg::INT_MSK_OFS, 32'h7);
        u_bc.st_on <= 1'b1;
        wait_st(1'b1);
        chk("payload", {ser_de, ser_data}, {1'b1, 24'h0});
        chk("irq", irq, 1);
        rchk("fn_crc", slb_pkg::FN_CRC_OFS, 32'h0);
        xfer(1'b1, slb_pkg::GEN_CFG_OFS, 32'h20);
        xfer(1'b1, slb_pkg::GEN_CFG_OFS, 32'h0);
        rchk("link_sts", slb_pkg::LINK_STS_OFS, 32'hF);
        frames(2);
        rchk("st_crc", slb_pkg::ST_CRC_OFS, 32'h2);
        rchk("fn_crc", slb_pkg::FN_CRC_OFS, 32'h2);
        u_bc.st_on <= 1'b0;
        wait_st(1'b0);
        chk("video", {ser_de, ser_data}, {1'b1, 24'hA5C3E1});
        chk("pass", u_bc.pass_r, 1);
        chk("err_frames", u_bc.err_frames, 0);
        frames(1);
        rchk("st_crc", slb_pkg::ST_CRC_OFS, 32'h2);
        rchk("fn_crc", slb_pkg::FN_CRC_OFS, 32'h3);
        rchk("int_sts", slb_pkg::INT_STS_OFS, 32'h7);
        xfer(1'b1, slb_pkg::INT_STS_OFS, 32'h7);
        @(posedge mclk);
        chk("irq", irq, 0);
        u_bc.st_on <= 1'b1;
        wait_st(1'b1);
        rchk("st_crc", slb_pkg::ST_CRC_OFS, 32'h0);
        chk("pass_run", u_bc.pass_r, 1);
        summarize();
    end
endmodule : tb
`default_nettype wire
